// [core/hst_top.sv]
// Top of the host serial transport: pins, config, handshake, receiver
`timescale 1ns/1ps
`default_nettype none
`include "hst_defines.svh"
module hst_top
    import hst_pkg::*;
#(
    parameter int FIFO_D = `HST_FIFO_D  // Receive FIFO depth
) (
    input  wire logic       clk,                  // 200 MHz clock
    input  wire logic       srst,                 // Sync reset, high
    input  wire logic       clk_en,               // Freezes state when low
    input  wire logic       transport_select_pin, // High SPI, low serial
    input  wire logic       crystal_present_pin,  // Sleep crystal fitted
    input  wire logic       end_device_cfg,       // Configured as end device
    input  wire logic       uart_rxd,             // Serial in pin
    output logic            uart_txd,             // Serial out pin
    input  wire logic       clear_to_send_in_n,   // Host clears us, low
    output logic            receive_ready_out_n,  // We can take a byte, low
    input  wire logic       rx_enable,            // Reception enabled
    input  wire logic       host_ready_line_n,    // Host ready pin, low
    output logic            slave_ready_line,     // Slave ready pin
    input  wire logic       spi_frame_done,       // Request frame received
    input  wire logic       spi_frame_sync,       // That frame is synchronous
    input  wire logic       func_done,            // Response frame built
    input  wire logic       func_ok,              // Function succeeded
    input  wire logic       func_bad_param,       // Parameter rejected
    input  wire logic       rsp_sent,             // Response clocked out
    input  wire logic       ind_fetched,          // Reset indication polled
    input  wire logic       reset_request_msg,    // Reset message decoded
    output logic            exec_start,           // Run requested function
    output logic [7:0]      status_byte,          // Status of last function
    output logic            sleep_req,            // Enter low-power state
    output logic            spi_mode,             // SPI transport chosen
    output logic            crystal_present,      // Sampled crystal pin
    output logic            cfg_valid,            // Pins have been sampled
    output logic [7:0]      rx_data,              // Received byte
    output logic            rx_valid,             // Received byte offered
    input  wire logic       rx_ready,             // Received byte taken
    input  wire logic [7:0] tx_data,              // Byte to send
    input  wire logic       tx_valid,             // Byte to send offered
    output logic            tx_ready              // Byte to send taken
);
    localparam hst_main_s MAIN_RST = '{rx_st: BS_IDLE, hs: HS_IDLE,
        status: status_success, slave_rdy: 1'b1, default: '0};

    hst_main_s q;            // State
    hst_main_s next_q;       // Next state
    logic      rst_all;      // Pin or message reset
    logic      uart_active;  // Serial transport in use
    logic      host_act;     // Host ready asserted
    logic      rx_bit_end;   // Last cycle of a received bit
    logic      tx_busy;      // Sender has a character

    hst_stream_if #(.W(8)) rxq_in ();   // Holding register to FIFO
    hst_stream_if #(.W(8)) rxq_out ();  // FIFO to user
    hst_stream_if #(.W(8)) txs ();      // User to sender

    // Reset from the pin or from a reset request message
    assign rst_all     = srst || q.soft_rst;
    assign uart_active = q.cfg_done && !q.spi_mode;
    assign host_act    = !q.s2[`HST_SY_HR];

    // Output wiring from state
    assign slave_ready_line = q.slave_rdy;
    assign exec_start       = q.exec;
    assign status_byte      = q.status;
    assign sleep_req        = q.sleep;
    assign spi_mode         = q.spi_mode;
    assign crystal_present  = q.xtal;
    assign cfg_valid        = q.cfg_done;

    // Ready to receive only while holding register is empty
    assign receive_ready_out_n = !(uart_active && rx_enable && !q.hold_v);

    // Receive path: holding register into FIFO into user
    assign rxq_in.valid  = q.hold_v;
    assign rxq_in.data   = q.hold;
    assign rx_valid      = rxq_out.valid;
    assign rx_data       = rxq_out.data;
    assign rxq_out.ready = rx_ready;

    // Transmit path, independent of the receiver
    assign txs.valid = tx_valid;
    assign txs.data  = tx_data;
    assign tx_ready  = txs.ready;

    // Receive FIFO
    hst_fifo #(
        .W (8),
        .D (FIFO_D)
    ) u_rx_fifo (
        .clk    (clk),
        .srst   (rst_all),
        .clk_en (clk_en),
        .wr     (rxq_in),
        .rd     (rxq_out)
    );

    // Character sender, gated by synchronised clear to send
    hst_uart_tx u_tx (
        .clk    (clk),
        .srst   (rst_all),
        .clk_en (clk_en),
        .enable (uart_active),
        .cts_n  (q.s2[`HST_SY_CTS]),
        .txs    (txs),
        .txd    (uart_txd),
        .busy   (tx_busy)
    );

    // Next-state logic for the whole block
    always_comb begin
        next_q          = q;
        next_q.soft_rst = 1'b0;
        next_q.exec     = 1'b0;
        rx_bit_end      = (q.rx_cnt == HST_BIT_CNT);

        // Two-stage pin synchronisers
        next_q.s1 = {crystal_present_pin, transport_select_pin,
                     host_ready_line_n, clear_to_send_in_n, uart_rxd};
        next_q.s2 = q.s1;

        // Sample config pins once the synchronisers have filled
        if (!q.cfg_done) begin
            if (q.cfg_cnt == `HST_CFG_WAIT) begin
                next_q.cfg_done = 1'b1;
                next_q.spi_mode = q.s2[`HST_SY_TS];
                next_q.xtal     = q.s2[`HST_SY_XP];
                if (q.s2[`HST_SY_TS]) begin
                    // Announce pending reset indication
                    next_q.hs        = HS_RSTIND;
                    next_q.slave_rdy = 1'b0;
                end
            end else begin
                next_q.cfg_cnt = q.cfg_cnt + 2'h1;
            end
        end

        // SPI handshake; serial transport leaves slave ready idle
        if (q.cfg_done && q.spi_mode) begin
            unique case (q.hs)
                HS_RSTIND: begin
                    // Low until the host polls the indication
                    next_q.slave_rdy = 1'b0;
                    if (ind_fetched) begin
                        next_q.hs        = HS_IDLE;
                        next_q.slave_rdy = 1'b1;
                        next_q.sleep     = end_device_cfg;
                    end
                end
                HS_IDLE: begin
                    // Host asserting ready starts a transaction
                    if (host_act) begin
                        next_q.hs    = HS_RECV;
                        next_q.slave_rdy = 1'b0;
                        next_q.sleep = 1'b0;
                    end
                end
                HS_RECV: begin
                    // Frame in progress
                    if (spi_frame_done) begin
                        if (spi_frame_sync) begin
                            next_q.hs   = HS_EXEC;
                            next_q.exec = 1'b1;
                        end else begin
                            next_q.hs        = HS_DONE;
                            next_q.slave_rdy = 1'b1;
                        end
                    end
                end
                HS_EXEC: begin
                    // Slave ready stays low until response built
                    if (func_done) begin
                        next_q.hs   = HS_SEND;
                        next_q.slave_rdy = 1'b1;
                        if (func_ok) begin
                            next_q.status = status_success;
                        end else if (func_bad_param) begin
                            next_q.status = status_bad_parameter;
                        end else begin
                            next_q.status = status_failure;
                        end
                    end
                end
                HS_SEND: begin
                    // Host clocks the whole response out
                    if (rsp_sent) begin
                        next_q.hs = HS_DONE;
                    end
                end
                HS_DONE: begin
                    // Wait for host to release its ready line
                    if (!host_act) begin
                        next_q.hs = HS_IDLE;
                    end
                end
            endcase
        end

        // Serial receiver, sampled mid-bit
        next_q.rx_cnt = q.rx_cnt + 1'b1;
        unique case (q.rx_st)
            BS_IDLE: begin
                next_q.rx_cnt = '0;
                if (uart_active && rx_enable && !q.s2[`HST_SY_RX]) begin
                    next_q.rx_st = BS_START;
                end
            end
            BS_START: begin
                // Confirm start bit at its middle
                if (q.rx_cnt == HST_HALF_CNT) begin
                    next_q.rx_cnt = '0;
                    next_q.rx_bit = '0;
                    next_q.rx_st  = q.s2[`HST_SY_RX] ? BS_IDLE : BS_DATA;
                end
            end
            BS_DATA: begin
                // Shift in LSB first
                if (rx_bit_end) begin
                    next_q.rx_cnt = '0;
                    next_q.rx_sh  = {q.s2[`HST_SY_RX], q.rx_sh[7:1]};
                    next_q.rx_bit = q.rx_bit + 3'h1;
                    if (q.rx_bit == 3'h7) begin
                        next_q.rx_st = BS_STOP;
                    end
                end
            end
            BS_STOP: begin
                // Keep byte only on a good stop bit
                if (rx_bit_end) begin
                    next_q.rx_st = BS_IDLE;
                    if (q.s2[`HST_SY_RX] && !q.hold_v) begin
                        next_q.hold_v = 1'b1;
                        next_q.hold   = q.rx_sh;
                    end
                end
            end
        endcase

        // Holding register empties into the FIFO
        if (q.hold_v && rxq_in.ready) begin
            next_q.hold_v = 1'b0;
        end

        // Reset request message takes effect next cycle
        if (reset_request_msg) begin
            next_q.soft_rst = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst_all) begin
            q <= MAIN_RST;
        end else if (clk_en) begin
            q <= next_q;
        end
    end

    // Checks on the block's own state and outputs
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst_all);

    // A full holding register refuses further bytes
    a_rts_hold_full: assert property (
        q.hold_v |-> receive_ready_out_n)
        else $error("receive ready low with holding register full");

    // Active-low ready when able to take a byte
    a_rts_low_ready: assert property (
        (uart_active && rx_enable && !q.hold_v) |-> !receive_ready_out_n)
        else $error("receive ready not asserted low when able");

    // Sender only starts after clear to send was low
    a_cts_gate: assert property (
        $rose(tx_busy) |-> !$past(q.s2[`HST_SY_CTS]))
        else $error("character started without clear to send");

    // Serial transport keeps slave ready idle high
    a_ready_uart_idle: assert property (
        uart_active |-> slave_ready_line)
        else $error("slave ready moved on serial transport");

    // No ready-to-send while the function runs
    a_exec_holds_ready: assert property (
        (q.hs == HS_EXEC) |-> !slave_ready_line)
        else $error("slave ready high before response built");

    // Send phase follows the response being built
    a_send_after_func: assert property (
        $rose(q.hs == HS_SEND) |-> ($past(func_done) && slave_ready_line))
        else $error("send phase without response built");

    // Pending reset indication holds slave ready low
    a_rstind_ready: assert property (
        (q.hs == HS_RSTIND) |-> !slave_ready_line)
        else $error("slave ready high with indication pending");

    // Sleep only after indication fetched by an end device
    a_sleep_cause: assert property (
        $rose(q.sleep) |-> ($past(ind_fetched) && $past(end_device_cfg)))
        else $error("sleep entered without fetched indication");

    // Bad parameter status encoding
    a_status_enc: assert property (
        (clk_en && q.hs == HS_EXEC && q.spi_mode && func_done && !func_ok
         && func_bad_param) |=> (status_byte == `HST_STAT_BAD))
        else $error("bad parameter status not encoded");

    // Start bit confirmed at mid-bit count
    a_mid_sample: assert property (
        $rose(q.rx_st == BS_DATA) |-> ($past(q.rx_cnt) == HST_HALF_CNT))
        else $error("start bit not checked at mid-bit");

    // Transport mode equals the sampled pin
    a_tsel_capture: assert property (
        $rose(q.cfg_done) |-> (q.spi_mode == $past(q.s2[`HST_SY_TS])))
        else $error("transport mode differs from pin");

    // Byte kept only with a high stop bit
    a_stop_bit: assert property (
        $rose(q.hold_v) |-> ($past(q.s2[`HST_SY_RX]) && $past(q.rx_st == BS_STOP)))
        else $error("byte kept without stop bit");

    // Message reset clears the block one cycle later
    a_soft_reset: assert property (@(posedge clk) disable iff (srst)
        q.soft_rst |=> (!q.cfg_done && q.rx_st == BS_IDLE && !q.hold_v))
        else $error("reset request did not reset block");

    // Main scenarios
    c_sync_txn: cover property (q.hs == HS_SEND ##[1:200] q.hs == HS_DONE);
    c_rx_byte: cover property ($rose(q.hold_v));
    c_duplex: cover property (tx_busy && q.rx_st == BS_DATA);
    c_sleep: cover property ($rose(q.sleep));
endmodule : hst_top
`default_nettype wire

// [core/hst_defines.svh]
// Timing, field position and code constants for the host serial transport
`ifndef HST_DEFINES_SVH
`define HST_DEFINES_SVH
`define HST_CLK_HZ    200000000
`define HST_BAUD      115200
`define HST_BIT_CYC   (`HST_CLK_HZ / `HST_BAUD)
`define HST_HALF_CYC  (`HST_BIT_CYC / 2)
`define HST_CNT_W     11
`define HST_FIFO_D    8
`define HST_CFG_WAIT  2'h3
`define HST_SY_RX     0
`define HST_SY_CTS    1
`define HST_SY_HR     2
`define HST_SY_TS     3
`define HST_SY_XP     4
`define HST_STAT_OK   8'h00
`define HST_STAT_FAIL 8'h01
`define HST_STAT_BAD  8'h02
`endif

// [core/hst_pkg.sv]
// Types and typed constants for the host serial transport
`default_nettype none
package hst_pkg;
`include "hst_defines.svh"
    typedef logic [`HST_CNT_W-1:0] hst_cnt_t;
    localparam hst_cnt_t HST_BIT_CNT  = hst_cnt_t'(`HST_BIT_CYC - 1);
    localparam hst_cnt_t HST_HALF_CNT = hst_cnt_t'(`HST_HALF_CYC - 1);
    typedef enum logic [3:0] {
        BS_IDLE = 4'h1, BS_START = 4'h2, BS_DATA = 4'h4, BS_STOP = 4'h8
    } hst_bit_e;
    typedef enum logic [5:0] {
        HS_RSTIND = 6'h01, HS_IDLE = 6'h02, HS_RECV = 6'h04,
        HS_EXEC = 6'h08, HS_SEND = 6'h10, HS_DONE = 6'h20
    } hst_hs_e;
    typedef enum logic [7:0] {
        status_success       = `HST_STAT_OK,
        status_failure       = `HST_STAT_FAIL,
        status_bad_parameter = `HST_STAT_BAD
    } hst_status_e;
    typedef struct packed {
        logic [4:0]  s1;
        logic [4:0]  s2;
        logic [1:0]  cfg_cnt;
        logic        cfg_done;
        logic        spi_mode;
        logic        xtal;
        hst_bit_e    rx_st;
        hst_cnt_t    rx_cnt;
        logic [2:0]  rx_bit;
        logic [7:0]  rx_sh;
        logic        hold_v;
        logic [7:0]  hold;
        hst_hs_e     hs;
        logic        slave_rdy;
        logic        exec;
        logic        sleep;
        hst_status_e status;
        logic        soft_rst;
    } hst_main_s;
endpackage : hst_pkg
`default_nettype wire

// [core/hst_stream_if.sv]
// Valid/ready word stream carrier between the transport modules
`timescale 1ns/1ps
`default_nettype none
interface hst_stream_if #(
    parameter int W = 8   // Word width
);
    logic         valid;  // Word offered
    logic         ready;  // Word taken
    logic [W-1:0] data;   // Word
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : hst_stream_if
`default_nettype wire

// [core/hst_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module hst_fifo #(
    parameter int W = 8,    // Word width
    parameter int D = 8     // Depth in words
) (
    input wire logic  clk,    // Clock
    input wire logic  srst,   // Sync reset
    input wire logic  clk_en, // Clock enable
    hst_stream_if.snk wr,     // Filling side
    hst_stream_if.src rd      // Draining side
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam logic [AW:0] FULL = (AW+1)'(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } hst_fifo_s;
    hst_fifo_s q;       // State
    hst_fifo_s next_q;  // Next state
    logic      push;    // Word enters
    logic      pop;     // Word leaves
    // Honest full and empty from the fill count
    assign wr.ready = (q.cnt != FULL);
    assign rd.valid = (q.cnt != '0);
    assign rd.data  = q.mem[q.rp];
    // Pointer and count update
    always_comb begin
        push   = wr.valid && wr.ready;
        pop    = rd.valid && rd.ready;
        next_q = q;
        if (push) begin
            next_q.mem[q.wp] = wr.data;
            next_q.wp = (q.wp == AW'(D-1)) ? '0 : q.wp + 1'b1;
        end
        if (pop) begin
            next_q.rp = (q.rp == AW'(D-1)) ? '0 : q.rp + 1'b1;
        end
        next_q.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else if (clk_en) begin
            q <= next_q;
        end
    end
endmodule : hst_fifo
`default_nettype wire

// [core/hst_uart_tx.sv]
// Serial character sender with clear-to-send gating
`timescale 1ns/1ps
`default_nettype none
module hst_uart_tx
    import hst_pkg::*;
(
    input wire logic  clk,    // Clock
    input wire logic  srst,   // Sync reset
    input wire logic  clk_en, // Clock enable
    input wire logic  enable, // Serial transport active
    input wire logic  cts_n,  // Synchronised clear to send
    hst_stream_if.snk txs,    // Bytes to send
    output logic      txd,    // Serial out, idle high
    output logic      busy    // Character in flight
);
    typedef struct packed {
        hst_bit_e   st;
        hst_cnt_t   cnt;
        logic [2:0] bit_i;
        logic [7:0] sh;
        logic       txd;
    } hst_tx_s;
    localparam hst_tx_s TX_RST = '{st: BS_IDLE, txd: 1'b1, default: '0};
    hst_tx_s q;       // State
    hst_tx_s next_q;  // Next state
    logic    bit_end; // Last cycle of a bit
    // Accept only when idle and the host clears us
    assign txs.ready = (q.st == BS_IDLE) && enable && !cts_n;
    assign txd       = q.txd;
    assign busy      = (q.st != BS_IDLE);
    // Start, eight data bits LSB first, stop
    always_comb begin
        next_q  = q;
        bit_end = (q.cnt == HST_BIT_CNT);
        next_q.cnt = bit_end ? '0 : q.cnt + 1'b1;
        unique case (q.st)
            BS_IDLE: begin
                next_q.cnt = '0;
                if (txs.valid && txs.ready) begin
                    next_q.sh  = txs.data;
                    next_q.txd = 1'b0;
                    next_q.st  = BS_START;
                end
            end
            BS_START: begin
                if (bit_end) begin
                    next_q.txd   = q.sh[0];
                    next_q.bit_i = '0;
                    next_q.st    = BS_DATA;
                end
            end
            BS_DATA: begin
                if (bit_end) begin
                    next_q.sh    = {1'b1, q.sh[7:1]};
                    next_q.txd   = q.sh[1];
                    next_q.bit_i = q.bit_i + 3'h1;
                    if (q.bit_i == 3'h7) begin
                        next_q.txd = 1'b1;
                        next_q.st  = BS_STOP;
                    end
                end
            end
            BS_STOP: begin
                if (bit_end) begin
                    next_q.st = BS_IDLE;
                end
            end
        endcase
    end
    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= TX_RST;
        end else if (clk_en) begin
            q <= next_q;
        end
    end
endmodule : hst_uart_tx
`default_nettype wire

// [test/hst_host_model.sv]
// Host-side partner: serial line driver, serial line catcher, clear-to-send
`timescale 1ns/1ps
`default_nettype none
module hst_host_model
    import hst_pkg::*;
(
    input  wire logic clk,   // Device clock
    input  wire logic txd,   // Device serial out
    output var logic  rxd,   // Device serial in
    output var logic  cts_n  // Clear to send, low
);
    localparam int BIT = int'(HST_BIT_CNT) + 1; // Cycles per bit
    logic [7:0] got;    // Last caught byte
    int         n_got;  // Bytes caught
    // Idle line, device held off until the bench clears it
    initial begin
        rxd   = 1'b1;   // Idle high
        cts_n = 1'b1;   // Flow control closed
        n_got = 0;
    end
    // Waits one bit time, then steps off the edge
    task automatic bt;
        repeat (BIT) @(posedge clk);
        #1;
    endtask : bt
    // Sends one character: start, eight data LSB first, stop
    task automatic send(input logic [7:0] b);
        rxd = 1'b0;     // Start bit
        bt();
        for (int i = 0; i < 8; i++) begin
            rxd = b[i]; // LSB first
            bt();
        end
        rxd = 1'b1;     // Stop bit, then idle
        bt();
    endtask : send
    // Catches characters from the device in mid-bit
    always begin
        @(negedge txd);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            got[i] = txd; // LSB first
        end
        repeat (BIT) @(posedge clk);
        if (txd === 1'b1) n_got++; // Count only with a good stop bit
    end
endmodule : hst_host_model
`default_nettype wire

// [test/host_serial_transport_tb.sv]
// Self-checking bench of the host serial transport
`timescale 1ns/1ps
`default_nettype none
module host_serial_transport_tb;
    logic clk, srst, clk_en, transport_select_pin, crystal_present_pin, end_device_cfg;
    logic uart_rxd, clear_to_send_in_n, rx_enable, host_ready_line_n, spi_frame_done;
    logic spi_frame_sync, func_done, func_ok, func_bad_param, rsp_sent, ind_fetched;
    logic reset_request_msg, rx_ready, tx_valid, uart_txd, receive_ready_out_n;
    logic slave_ready_line, exec_start, sleep_req, spi_mode, crystal_present, cfg_valid;
    logic rx_valid, tx_ready;
    logic [7:0] status_byte, rx_data, tx_data;
    int   errors, n_checks;
    hst_top dut (.clk, .srst, .clk_en, .transport_select_pin, .crystal_present_pin,
        .end_device_cfg, .uart_rxd, .uart_txd, .clear_to_send_in_n, .receive_ready_out_n,
        .rx_enable, .host_ready_line_n, .slave_ready_line, .spi_frame_done, .spi_frame_sync,
        .func_done, .func_ok, .func_bad_param, .rsp_sent, .ind_fetched, .reset_request_msg,
        .exec_start, .status_byte, .sleep_req, .spi_mode, .crystal_present, .cfg_valid,
        .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_ready);
    hst_host_model host (.clk, .txd(uart_txd), .rxd(uart_rxd), .cts_n(clear_to_send_in_n));
    // Compares one value and counts it
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Verdict and end of run
    task automatic conclude;
        if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // Steps n edges, then settles just after
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // One-cycle strobe
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask : pulse
    // Reset values, then serial mode chosen by the pin
    task automatic t_defaults;
        chk(slave_ready_line, 1); chk(uart_txd, 1); chk(status_byte, 0);
        chk(receive_ready_out_n, 1);
        cyc(6);
        chk(cfg_valid, 1); chk(spi_mode, 0); chk(crystal_present, 1);
        chk(receive_ready_out_n, 0); chk(slave_ready_line, 1);
        rx_enable = 1'b0;
        cyc(1);
        chk(receive_ready_out_n, 1);
        rx_enable = 1'b1;
    endtask : t_defaults
    // Held off by clear to send, then both directions at once
    task automatic t_serial;
        tx_data  = 8'h3C;
        tx_valid = 1'b1;
        cyc(5);
        chk(tx_ready, 0); chk(uart_txd, 1);
        fork
            host.send(8'hA5);
            begin
                host.cts_n = 1'b0;
                for (int k = 0; k < 20 && tx_ready !== 1'b1; k++) cyc(1);
                cyc(1);
                tx_valid    = 1'b0;
                host.cts_n  = 1'b1; // Closing mid character must not cut it
            end
        join
        cyc(200);
        chk(host.got, 8'h3C); chk(8'(host.n_got), 1);
        chk(rx_valid, 1); chk(rx_data, 8'hA5);
        pulse(rx_ready);
        chk(rx_valid, 0);
    endtask : t_serial
    // Soft reset into SPI, indication fetch, three synchronous requests
    task automatic t_spi;
        logic [7:0] exp;
        transport_select_pin = 1'b1;
        pulse(reset_request_msg);
        cyc(8);
        chk(spi_mode, 1); chk(slave_ready_line, 0); chk(receive_ready_out_n, 1);
        end_device_cfg = 1'b1;
        pulse(ind_fetched);
        chk(slave_ready_line, 1); chk(sleep_req, 1);
        for (int i = 0; i < 3; i++) begin
            exp = (i == 0) ? 8'h02 : (i == 1) ? 8'h00 : 8'h01;
            host_ready_line_n = 1'b0;
            cyc(4);
            chk(slave_ready_line, 0); chk(sleep_req, 0);
            pulse(spi_frame_done);
            chk(exec_start, 1); chk(slave_ready_line, 0);
            func_ok        = (i == 1);
            func_bad_param = (i == 0);
            pulse(func_done);
            chk(slave_ready_line, 1); chk(status_byte, exp);
            pulse(rsp_sent);
            host_ready_line_n = 1'b1;
            cyc(4);
        end
        // Asynchronous request: no execution, ready high once frame is in
        spi_frame_sync    = 1'b0;
        host_ready_line_n = 1'b0;
        cyc(4);
        chk(slave_ready_line, 0);
        pulse(spi_frame_done);
        chk(exec_start, 0); chk(slave_ready_line, 1); chk(status_byte, 8'h01);
        host_ready_line_n = 1'b1;
        cyc(4);
        chk(slave_ready_line, 1);
    endtask : t_spi
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Main sequence
    initial begin
        {clk_en, crystal_present_pin, spi_frame_sync, rx_enable, host_ready_line_n} = 5'h1F;
        {srst, transport_select_pin, end_device_cfg, spi_frame_done, func_done} = 5'h10;
        {func_ok, func_bad_param, rsp_sent, ind_fetched, reset_request_msg} = 5'h00;
        {rx_ready, tx_valid, tx_data} = 10'h000;
        errors   = 0;
        n_checks = 0;
        cyc(10);
        srst = 1'b0;
        t_defaults();
        t_serial();
        t_spi();
        conclude();
    end
    // Watchdog against a hang
    initial begin
        #500000;
        errors++;
        conclude();
    end
endmodule : host_serial_transport_tb
`default_nettype wire
